// file: core/gsf_defs.vh
// ===================================================================
// General status flags: shared constants
// ===================================================================
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit register address, 16-bit register data
// Notes:   Included by the status block; definitions only
//
// Contract
// - Status word resets 1180h at offset 21h
// - Bit 15 ORs unmasked fault status bits
// - Bit 12 high while trim load runs
// - Bit 11 shows self-test enabled
// - Sticky flags clear on read unless held
// - Bit 10 sticky self-test complete
// - Bit 9 sticky self-test failed
// - Bit 8 sticky reset seen, no interrupt
// - Bit 7 high once applied equals target
// - Unlimited slew settles within three cycles
// - Limited slew raises event on arrival
// - Slew off early steps applied to target
// - Bit 6 sticky end of conversion
// - Bit 5 live converter busy, no interrupt
// - Bit 4 live supply high, no interrupt
// - Bit 3 sticky break stop-bit error
// - Bit 2 sticky break parity error
// - Bit 1 sticky character stop-bit error
// - Bit 0 sticky character parity error
// - Mask bit 1 blocks interrupt, status sets
// - Summary output ORs unmasked bits 10, 9, 7, 6 and 3 to 0

`ifndef GSF_DEFS_VH
`define GSF_DEFS_VH

// ===================================================================
// Register offsets
// ===================================================================
`define GSF_OFS_STATUS      8'h21
`define GSF_OFS_TARGET      8'h30
`define GSF_OFS_SLEW_CTRL   8'h31
`define GSF_OFS_APPLIED     8'h32

// ===================================================================
// Status word field positions
// ===================================================================
`define GSF_BIT_ALARM       15
`define GSF_BIT_TRIM_BUSY   12
`define GSF_BIT_ST_ENABLED  11
`define GSF_BIT_ST_DONE     10
`define GSF_BIT_ST_FAIL     9
`define GSF_BIT_RESET_SEEN  8
`define GSF_BIT_SETTLED     7
`define GSF_BIT_EOC         6
`define GSF_BIT_CONV_BUSY   5
`define GSF_BIT_SUPPLY_HI   4
`define GSF_BIT_BRK_FRAME   3
`define GSF_BIT_BRK_PARITY  2
`define GSF_BIT_CHR_FRAME   1
`define GSF_BIT_CHR_PARITY  0

// ===================================================================
// Field groups and reset values
// ===================================================================
`define GSF_STATUS_RESET    16'h1180
`define GSF_STICKY_BITS     16'h074F
`define GSF_MASKABLE_BITS   16'h06CF
`define GSF_SLEW_EN_BIT     0
`define GSF_STEP_LSB        8
`define GSF_CTRL_RESET      16'h0100

// ===================================================================
// Timing
// ===================================================================
`define GSF_CLK_PERIOD_NS   10
`define GSF_SETTLE_MAX_CLK  3
`define GSF_SLEW_TICK_CLK   16

`endif

// file: core/gsf_general_status_flags.v
// Purpose: General status word with live and sticky flags, plus
//          the output code slew engine that drives the settled flag
// Assumes: Event pulses and live levels come from logic on clock;
//          the supply comparator is asynchronous
// Notes:   Read data stand one cycle after the read strobe

`timescale 1ns/1ps

`include "gsf_defs.vh"

module gsf_general_status_flags
#(
   parameter CODE_W     = 16,
   parameter SLEW_TICKS = `GSF_SLEW_TICK_CLK
)
(
   // Clock, reset and enable
   input  wire                clock,
   input  wire                sys_rst,
   input  wire                clk_en,

   // Register port
   input  wire [7:0]          reg_addr,
   input  wire [15:0]         reg_wdata,
   input  wire                reg_wr,
   input  wire                reg_rd,
   output reg  [15:0]         reg_rdata,

   // Fault status word and masks from neighbouring registers
   input  wire [15:0]         alarm_status_word,
   input  wire [15:0]         alarm_status_mask,
   input  wire [15:0]         general_status_mask,

   // Trim loader
   input  wire                trim_load_done,

   // Register self-test
   input  wire                selftest_enabled_flag,
   input  wire                selftest_complete,
   input  wire                selftest_failed,

   // Diagnostic converter
   input  wire                adc_end_of_conversion,
   input  wire                adc_converting,

   // Output stage supply comparator
   input  wire                supply_high_raw,

   // Serial receive errors
   input  wire                break_frame_err,
   input  wire                break_parity_err,
   input  wire                char_frame_err,
   input  wire                char_parity_err,

   // Outputs
   output reg  [CODE_W-1:0]   applied_code,
   output reg                 gen_irq_summary
);

   // ================================================================
   // Local definitions
   // ================================================================
   localparam [15:0] STICKY   = `GSF_STICKY_BITS;
   localparam [15:0] MASKABLE = `GSF_MASKABLE_BITS;
   localparam integer TICK_M1  = SLEW_TICKS - 1;
   localparam [15:0] TICK_MAX = TICK_M1[15:0];

   // Slew engine states
   localparam [1:0] SL_IDLE = 2'b00;
   localparam [1:0] SL_UP   = 2'b01;
   localparam [1:0] SL_DOWN = 2'b10;

   // Address match used by both strobes
   function hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         hit = (addr == offset);
      end
   endfunction

   // ================================================================
   // Declarations
   // ================================================================
   reg  [15:0]        sticky_r;
   reg                trim_busy_r;
   reg  [CODE_W-1:0]  target_r;
   reg  [15:0]        ctrl_r;
   reg  [15:0]        tick_r;
   reg  [1:0]         slew_state_r;
   reg  [1:0]         slew_state_nxt;
   reg                settled_r;
   reg  [2:0]         sup_sync_r;
   reg                supply_hi_r;
   reg  [CODE_W-1:0]  applied_nxt;
   reg  [15:0]        status_now;
   reg  [15:0]        sticky_evt;
   reg  [CODE_W-1:0]  step;
   reg  [CODE_W-1:0]  diff;

   wire               wr_status;
   wire               rd_status;
   wire               wr_target;
   wire               wr_ctrl;
   wire               slew_en;
   wire               alarm_any;
   wire [15:0]        sticky_nxt;

   // ================================================================
   // Register decode
   // ================================================================
   // Writes to the status word are dropped
   assign wr_status = reg_wr & hit(reg_addr, `GSF_OFS_STATUS);
   assign rd_status = reg_rd & hit(reg_addr, `GSF_OFS_STATUS);
   assign wr_target = reg_wr & hit(reg_addr, `GSF_OFS_TARGET);
   assign wr_ctrl   = reg_wr & hit(reg_addr, `GSF_OFS_SLEW_CTRL);
   assign slew_en   = ctrl_r[`GSF_SLEW_EN_BIT];

   // Fault summary from the unmasked fault status bits
   assign alarm_any = |(alarm_status_word & ~alarm_status_mask);

   // ================================================================
   // Sticky event sources
   // ================================================================
   // Event vector lined up with the status word bits
   always @*
   begin
      sticky_evt = 16'h0000;
      sticky_evt[`GSF_BIT_ST_DONE]    = selftest_complete;
      sticky_evt[`GSF_BIT_ST_FAIL]    = selftest_failed;
      sticky_evt[`GSF_BIT_RESET_SEEN] = 1'b0;
      sticky_evt[`GSF_BIT_EOC]        = adc_end_of_conversion;
      sticky_evt[`GSF_BIT_BRK_FRAME]  = break_frame_err;
      sticky_evt[`GSF_BIT_BRK_PARITY] = break_parity_err;
      sticky_evt[`GSF_BIT_CHR_FRAME]  = char_frame_err;
      sticky_evt[`GSF_BIT_CHR_PARITY] = char_parity_err;
   end

   // ================================================================
   // Sticky flags
   // ================================================================
   // One next-state term per bit; set wins over clear on read
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1)
      begin : g_sticky
         if (STICKY[gi])
         begin : g_on
            assign sticky_nxt[gi] = (sticky_r[gi] & ~rd_status)
                                    | sticky_evt[gi];
         end
         else
         begin : g_off
            assign sticky_nxt[gi] = 1'b0;
         end
      end
   endgenerate

   // Flags register; reset seen flag comes up set
   always @(posedge clock)
   begin
      if (sys_rst)
         sticky_r <= `GSF_STATUS_RESET & STICKY;
      else if (clk_en)
         sticky_r <= sticky_nxt;
   end

   // ================================================================
   // Trim load busy
   // ================================================================
   // Busy from power-up until the loader reports completion
   always @(posedge clock)
   begin
      if (sys_rst)
         trim_busy_r <= 1'b1;
      else if (clk_en && trim_load_done)
         trim_busy_r <= 1'b0;
   end

   // ================================================================
   // Supply comparator synchroniser
   // ================================================================
   // Three stages; the level changes once stages two and three agree
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         sup_sync_r  <= 3'b000;
         supply_hi_r <= 1'b0;
      end
      else if (clk_en)
      begin
         sup_sync_r <= {sup_sync_r[1:0], supply_high_raw};
         if (sup_sync_r[1] == sup_sync_r[2])
            supply_hi_r <= sup_sync_r[2];
      end
   end

   // ================================================================
   // Slew control registers
   // ================================================================
   // Target code and slew control, written by software
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         target_r <= {CODE_W{1'b0}};
         ctrl_r   <= `GSF_CTRL_RESET;
      end
      else if (clk_en)
      begin
         if (wr_target)
            target_r <= reg_wdata[CODE_W-1:0];
         if (wr_ctrl)
            ctrl_r <= reg_wdata;
      end
   end

   // ================================================================
   // Slew engine
   // ================================================================
   // Step size, zero treated as one
   always @*
   begin
      step = {CODE_W{1'b0}};
      step[7:0] = ctrl_r[15:`GSF_STEP_LSB];
      if (step == {CODE_W{1'b0}})
         step = {{(CODE_W-1){1'b0}}, 1'b1};
   end

   // Direction and next applied code
   always @*
   begin
      applied_nxt    = applied_code;
      slew_state_nxt = SL_IDLE;
      diff           = {CODE_W{1'b0}};
      if (!slew_en)
      begin
         // Step straight to target, also when cut short
         applied_nxt = target_r;
      end
      else if (applied_code < target_r)
      begin
         slew_state_nxt = SL_UP;
         diff = target_r - applied_code;
         if (tick_r == TICK_MAX)
         begin
            if (diff <= step)
               applied_nxt = target_r;
            else
               applied_nxt = applied_code + step;
         end
      end
      else if (applied_code > target_r)
      begin
         slew_state_nxt = SL_DOWN;
         diff = applied_code - target_r;
         if (tick_r == TICK_MAX)
         begin
            if (diff <= step)
               applied_nxt = target_r;
            else
               applied_nxt = applied_code - step;
         end
      end
   end

   // Step timer, applied code and state
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         applied_code <= {CODE_W{1'b0}};
         tick_r       <= 16'h0000;
         slew_state_r <= SL_IDLE;
      end
      else if (clk_en)
      begin
         applied_code <= applied_nxt;
         slew_state_r <= slew_state_nxt;
         case (slew_state_nxt)
            SL_UP, SL_DOWN:
               if (tick_r == TICK_MAX)
                  tick_r <= 16'h0000;
               else
                  tick_r <= tick_r + 16'h0001;
            SL_IDLE:
               tick_r <= 16'h0000;
            default:
               tick_r <= 16'h0000;
         endcase
      end
   end

   // Settled flag; rises the cycle after the codes meet
   always @(posedge clock)
   begin
      if (sys_rst)
         settled_r <= 1'b1;
      else if (clk_en)
         settled_r <= (applied_code == target_r);
   end

   // ================================================================
   // Status word assembly
   // ================================================================
   // Live bits beside sticky bits; reserved bits stay zero
   always @*
   begin
      status_now = sticky_r;
      status_now[`GSF_BIT_ALARM]      = alarm_any;
      status_now[`GSF_BIT_TRIM_BUSY]  = trim_busy_r;
      status_now[`GSF_BIT_ST_ENABLED] = selftest_enabled_flag;
      status_now[`GSF_BIT_SETTLED]    = settled_r;
      status_now[`GSF_BIT_CONV_BUSY]  = adc_converting;
      status_now[`GSF_BIT_SUPPLY_HI]  = supply_hi_r;
      status_now[14:13]               = 2'b00;
   end

   // ================================================================
   // Read data
   // ================================================================
   // Value sampled before the clear; zero for unmapped offsets
   always @(posedge clock)
   begin
      if (sys_rst)
         reg_rdata <= 16'h0000;
      else if (clk_en)
      begin
         reg_rdata <= 16'h0000;
         if (rd_status)
            reg_rdata <= status_now;
         else if (reg_rd && hit(reg_addr, `GSF_OFS_TARGET))
            reg_rdata <= target_r;
         else if (reg_rd && hit(reg_addr, `GSF_OFS_SLEW_CTRL))
            reg_rdata <= ctrl_r;
         else if (reg_rd && hit(reg_addr, `GSF_OFS_APPLIED))
            reg_rdata <= applied_code;
      end
   end

   // ================================================================
   // Interrupt summary
   // ================================================================
   // Only maskable bits whose mask bit is zero contribute
   always @(posedge clock)
   begin
      if (sys_rst)
         gen_irq_summary <= 1'b0;
      else if (clk_en)
         gen_irq_summary <= |(status_now & MASKABLE
                              & ~general_status_mask);
   end

endmodule

// file: dv/gsf_monitor.sv
// Purpose: Port checker for the general status flags block
// Assumes: clk_en held high while slew timing is judged
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps

module gsf_monitor
#(
   parameter CODE_W = 16
)
(
   // Clock and control
   input wire              clock,
   input wire              sys_rst,
   input wire              clk_en,
   // Register port
   input wire [7:0]        reg_addr,
   input wire [15:0]       reg_wdata,
   input wire              reg_wr,
   input wire              reg_rd,
   input wire [15:0]       reg_rdata,
   // Status sources
   input wire [15:0]       alarm_status_word,
   input wire [15:0]       alarm_status_mask,
   input wire [15:0]       general_status_mask,
   input wire              selftest_enabled_flag,
   input wire              adc_converting,
   input wire              char_parity_err,
   // Outputs
   input wire [CODE_W-1:0] applied_code,
   input wire              gen_irq_summary
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   reg              slew_on_r;
   reg [CODE_W-1:0] target_r;
   wire             rd21 = reg_rd && clk_en && reg_addr == 8'h21;

   // Shadow of slew enable and target code
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         slew_on_r <= 1'b0;
         target_r  <= {CODE_W{1'b0}};
      end
      else if (reg_wr && clk_en && reg_addr == 8'h31)
         slew_on_r <= reg_wdata[0];
      else if (reg_wr && clk_en && reg_addr == 8'h30)
         target_r <= reg_wdata[CODE_W-1:0];
   end

   // Unlimited slew settles quickly
   property p_settle;
      (reg_wr && clk_en && reg_addr == 8'h30 && !slew_on_r) |->
         ##[1:3] applied_code == target_r;
   endproperty

   a_rdata_idle_zero: assert property ((!reg_rd && clk_en) |=>
      reg_rdata == 16'h0000) else $error("read data not idle zero");
   a_reserved_bits_zero: assert property (rd21 |=>
      reg_rdata[14:13] == 2'b00) else $error("reserved bits set");
   a_alarm_or_live: assert property (rd21 |=> reg_rdata[15] ==
      |($past(alarm_status_word) & ~$past(alarm_status_mask)))
      else $error("alarm summary bit wrong");
   a_live_bits_shown: assert property (rd21 |=>
      reg_rdata[11] == $past(selftest_enabled_flag) &&
      reg_rdata[5] == $past(adc_converting)) else $error("live bit wrong");
   a_sticky_kept_read: assert property ((char_parity_err && clk_en)
      ##1 !rd21 ##1 rd21 |=> reg_rdata[0]) else $error("sticky flag lost");
   a_masked_no_summary: assert property ((clk_en &&
      general_status_mask == 16'hFFFF)[*2] |-> !gen_irq_summary)
      else $error("summary raised while masked");
   a_settle_fast: assert property (p_settle)
      else $error("applied code late");
   a_step_on_off: assert property ((reg_wr && clk_en &&
      reg_addr == 8'h31 && !reg_wdata[0] && slew_on_r) |->
      ##[1:3] applied_code == target_r) else $error("no step to target");

   c_status_read: cover property (rd21);
   c_summary_up: cover property ($rose(gen_irq_summary));
   c_slew_on: cover property (reg_wr && reg_addr == 8'h31 && reg_wdata[0]);
endmodule

bind gsf_general_status_flags gsf_monitor #(.CODE_W(CODE_W)) i_mon
(
   .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .alarm_status_word(alarm_status_word),
   .alarm_status_mask(alarm_status_mask),
   .general_status_mask(general_status_mask),
   .selftest_enabled_flag(selftest_enabled_flag),
   .adc_converting(adc_converting), .char_parity_err(char_parity_err),
   .applied_code(applied_code), .gen_irq_summary(gen_irq_summary)
);

// file: dv/gsf_general_status_flags_tb.sv
// Purpose: Self-checking bench for the general status flags block
// Assumes: Short slew tick for a quick run
// Notes:   Events drive one-cycle pulses on the clock, except ev[5] held over two reads
`timescale 1ns/1ps

module gsf_general_status_flags_tb;
   reg         clock, sys_rst, clk_en, reg_wr, reg_rd, trim_load_done;
   reg         selftest_enabled_flag, adc_converting, supply_high_raw;
   reg  [7:0]  reg_addr;
   reg  [15:0] reg_wdata, alarm_status_word, alarm_status_mask;
   reg  [15:0] general_status_mask;
   reg  [6:0]  ev;
   wire [15:0] reg_rdata, applied_code;
   wire        gen_irq_summary;
   integer     err_total, comparisons, k, n;

   gsf_general_status_flags #(.CODE_W(16), .SLEW_TICKS(2)) i_dut
   (
      .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .alarm_status_word(alarm_status_word),
      .alarm_status_mask(alarm_status_mask),
      .general_status_mask(general_status_mask),
      .trim_load_done(trim_load_done),
      .selftest_enabled_flag(selftest_enabled_flag),
      .selftest_complete(ev[0]), .selftest_failed(ev[1]),
      .adc_end_of_conversion(ev[2]), .adc_converting(adc_converting),
      .supply_high_raw(supply_high_raw), .break_frame_err(ev[3]),
      .break_parity_err(ev[4]), .char_frame_err(ev[5]),
      .char_parity_err(ev[6]), .applied_code(applied_code),
      .gen_irq_summary(gen_irq_summary)
   );

   // ================================================================
   // Tasks
   // ================================================================
   task chk(input string nm, input [15:0] e, input [15:0] g);
   begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
         err_total = err_total + 1;
         $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
   end
   endtask

   task wr(input [7:0] a, input [15:0] d);
   begin
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   end
   endtask

   task rdchk(input [7:0] a, input [15:0] e);
   begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1;
      chk("rdata", e, reg_rdata);
   end
   endtask

   // Summary output sampled three cycles on
   task chk_sum(input e);
   begin
      repeat (3) @(posedge clock);
      #1;
      chk("summary", {15'h0, e}, {15'h0, gen_irq_summary});
   end
   endtask

   // Applied code sampled three cycles on
   task chk_app(input [15:0] e);
   begin
      repeat (3) @(posedge clock);
      #1;
      chk("applied", e, applied_code);
   end
   endtask

   task conclude;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask

   // Clock at 100 MHz
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ================================================================
   // Main sequence
   // ================================================================
   initial
   begin
      err_total = 0;
      comparisons = 0;
      {sys_rst, clk_en} = 2'b11;
      {reg_wr, reg_rd, trim_load_done, ev} = 10'h000;
      {selftest_enabled_flag, adc_converting, supply_high_raw} = 3'b000;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      alarm_status_word = 16'h0000;
      alarm_status_mask = 16'hFFFF;
      general_status_mask = 16'hFFFF;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      rdchk(8'h21, 16'h1180);
      rdchk(8'h21, 16'h1080);
      @(posedge clock);
      trim_load_done <= 1'b1;
      @(posedge clock);
      trim_load_done <= 1'b0;
      rdchk(8'h21, 16'h0080);
      $display("test reset and trim done");
      // Each sticky event sets its bit once, cleared by the read
      for (k = 0; k < 7; k = k + 1)
      begin
         n = (k == 0) ? 10 : (k == 1) ? 9 : (k == 2) ? 6 : 6 - k;
         @(posedge clock);
         ev[k] <= 1'b1;
         @(posedge clock);
         ev[k] <= 1'b0;
         rdchk(8'h21, 16'h0080 | (16'h0001 << n));
         rdchk(8'h21, 16'h0080);
      end
      // Event in the read cycle survives the clear
      @(posedge clock);
      ev[6] <= 1'b1;
      reg_addr <= 8'h21;
      reg_rd <= 1'b1;
      @(posedge clock);
      ev[6] <= 1'b0;
      reg_rd <= 1'b0;
      rdchk(8'h21, 16'h0081);
      rdchk(8'h21, 16'h0080);
      // Held condition keeps the flag through reads
      @(posedge clock);
      ev[5] <= 1'b1;
      rdchk(8'h21, 16'h0082);
      rdchk(8'h21, 16'h0082);
      @(posedge clock);
      ev[5] <= 1'b0;
      rdchk(8'h21, 16'h0082);
      rdchk(8'h21, 16'h0080);
      $display("test sticky flags");
      // Masking and summary
      @(posedge clock);
      ev[6] <= 1'b1;
      @(posedge clock);
      ev[6] <= 1'b0;
      chk_sum(1'b0);
      general_status_mask <= 16'hFFFE;
      chk_sum(1'b1);
      rdchk(8'h21, 16'h0081);
      chk_sum(1'b0);
      general_status_mask <= 16'hFF7F;
      chk_sum(1'b1);
      // Live bits, and status-only bits kept off the summary
      general_status_mask <= 16'hFFCF;
      {selftest_enabled_flag, adc_converting, supply_high_raw} <= 3'b111;
      alarm_status_word <= 16'h0001;
      alarm_status_mask <= 16'h0000;
      repeat (3) @(posedge clock);
      chk_sum(1'b0);
      rdchk(8'h21, 16'h88B0);
      alarm_status_mask <= 16'h0001;
      rdchk(8'h21, 16'h08B0);
      {selftest_enabled_flag, adc_converting, supply_high_raw} <= 3'b000;
      general_status_mask <= 16'hFFFF;
      repeat (5) @(posedge clock);
      $display("test masks and live bits");
      // Writes to the status word and unmapped reads
      wr(8'h21, 16'hFFFF);
      rdchk(8'h21, 16'h0080);
      rdchk(8'h7F, 16'h0000);
      $display("test write ignore");
      // Slew off then on
      wr(8'h30, 16'h1234);
      chk_app(16'h1234);
      rdchk(8'h32, 16'h1234);
      rdchk(8'h21, 16'h0080);
      // Only the settled bit left unmasked while slewing
      general_status_mask <= 16'hFF7F;
      wr(8'h31, 16'h0001);
      wr(8'h30, 16'h123A);
      repeat (3) @(posedge clock);
      rdchk(8'h21, 16'h0000);
      chk_sum(1'b0);
      n = 0;
      while (applied_code !== 16'h123A && n < 100)
      begin
         @(posedge clock);
         #1;
         n = n + 1;
      end
      chk("slew wait", 16'h123A, applied_code);
      chk_sum(1'b1);
      rdchk(8'h21, 16'h0080);
      wr(8'h31, 16'h0100);
      wr(8'h31, 16'h0001);
      wr(8'h30, 16'h1300);
      wr(8'h31, 16'h0100);
      chk_app(16'h1300);
      $display("test slew");
      // Reset in mid-run
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      rdchk(8'h21, 16'h1180);
      $display("test second reset");
      conclude;
   end
endmodule
